// File: video_input_route_select_bench.sv
/*
 * Self-checking bench: six- and three-input parts on one serial bus.
 * Assumes the checker file is compiled alongside.
 */
`timescale 1ns/1ps
module video_input_route_select_bench;
    localparam int Q = 5;
    localparam logic [6:0] ADR_A = 7'h20;
    localparam logic [6:0] ADR_B = 7'h21;
    // predefined schemes: format, first, second, third per code
    localparam logic [15:0] T6 [16] = '{16'h1100, 16'h1200, 16'h1300,
        16'h1400, 16'h1500, 16'h1600, 16'h2140, 16'h2250, 16'h2360,
        16'h3145, 16'h3236, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    localparam logic [15:0] T3 [16] = '{16'h1100, 16'h0, 16'h0, 16'h1200,
        16'h1300, 16'h0, 16'h2120, 16'h0, 16'h0, 16'h3123, 16'h0, 16'h0,
        16'h0, 16'h0, 16'h0, 16'h0};
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic scl_drv = 1'b1;
    logic sda_drv = 1'b1;
    logic sda_w;
    logic [2:0] m1[2], m2[2], m3[2], pw[2];
    logic [1:0] cf[2];
    logic vl[2], ma[2], so[2], oe[2];
    logic [7:0] mreg[2][3];
    logic [31:0] seed = 32'hF87E;
    logic [3:0] v;
    int fail_count = 0;
    int checks = 0;

    // ********************************
    // clock, bus wire, instances
    // ********************************
    always #10 clk_sys_in = ~clk_sys_in;
    // open drain: any low driver wins
    assign sda_w = sda_drv & ~(oe[0] & ~so[0]) & ~(oe[1] & ~so[1]);
    vir_top #(.SIX_INPUT(1)) i_dut (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .scl_in(scl_drv), .sda_in(sda_w),
        .alsb_in(1'b0), .sda_out(so[0]), .sda_oe_out(oe[0]),
        .mux_first_out(m1[0]), .mux_second_out(m2[0]),
        .mux_third_out(m3[0]), .chan_power_out(pw[0]),
        .core_format_out(cf[0]), .route_valid_out(vl[0]),
        .manual_active_out(ma[0]));
    vir_top #(.SIX_INPUT(0)) i_dut_three (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .scl_in(scl_drv), .sda_in(sda_w),
        .alsb_in(1'b1), .sda_out(so[1]), .sda_oe_out(oe[1]),
        .mux_first_out(m1[1]), .mux_second_out(m2[1]),
        .mux_third_out(m3[1]), .chan_power_out(pw[1]),
        .core_format_out(cf[1]), .route_valid_out(vl[1]),
        .manual_active_out(ma[1]));

    // ********************************
    // reference model
    // ********************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h0);
    endfunction
    function automatic int rid(input logic [7:0] o);
        return (o == 8'h00) ? 0 : (o == 8'hC3) ? 1 : (o == 8'hC4) ? 2 : -1;
    endfunction
    // manual selector code to input number, zero where no connection
    function automatic int mmap(input int six, input int k, input int c);
        if (six != 0) return (k == 0) ? ((c >= 1 && c <= 6) ? c : 0) :
            (k == 1) ? ((c >= 3 && c <= 6) ? c : 0) :
            ((c == 2 || c == 5 || c == 6) ? c : 0);
        return (k == 2) ? ((c == 5) ? 3 : 0) : (c == 5) ? 3 :
            (c == 4) ? 2 : (c == 1 && k == 0) ? 1 : 0;
    endfunction
    function automatic logic [14:0] exp_of(input int i);
        logic [15:0] t;
        int c, a, b, d, p;
        t = (i == 0) ? T6[mreg[i][0][3:0]] : T3[mreg[i][0][3:0]];
        c = t[15:12];
        a = t[11:8];
        b = t[7:4];
        d = t[3:0];
        // manual fields replace only the muxes the format needs
        if (mreg[i][2][7] && c != 0) begin
            a = mmap(i == 0, 0, mreg[i][1][2:0]);
            b = (c > 1) ? mmap(i == 0, 1, mreg[i][1][6:4]) : 0;
            d = (c > 2) ? mmap(i == 0, 2, mreg[i][2][2:0]) : 0;
        end
        p = (c == 1) ? 1 : (c == 2) ? 3 : (c == 3) ? 7 : 0;
        return {c != 0, c[1:0], p[2:0], a[2:0], b[2:0], d[2:0]};
    endfunction
    function automatic logic [14:0] got(input int i);
        return {vl[i], cf[i], pw[i], m1[i], m2[i], m3[i]};
    endfunction

    // ********************************
    // checks and bus tasks
    // ********************************
    task automatic chk(input logic [14:0] g, input logic [14:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_all;
        for (int i = 0; i < 2; i++) begin
            chk(got(i), exp_of(i));
            chk(15'(ma[i]), 15'(mreg[i][2][7]));
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #2;
    endtask
    // sda moves mid-low, sampled mid-high
    task automatic bitx(input logic d, output logic s);
        sda_drv = d;
        tick(Q);
        scl_drv = 1'b1;
        tick(Q);
        s = sda_w;
        tick(Q);
        scl_drv = 1'b0;
        tick(Q);
    endtask
    // start is cond(1,0); stop is cond(0,1)
    task automatic cond(input logic s0, input logic s1);
        sda_drv = s0;
        tick(Q);
        scl_drv = 1'b1;
        tick(Q);
        sda_drv = s1;
        tick(Q);
        if (!s1) scl_drv = 1'b0;
        tick(Q);
    endtask
    task automatic tx(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        ack = !s;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o,
                      input int n, input logic [15:0] d);
        logic ack;
        logic [7:0] b;
        cond(1'b1, 1'b0);
        tx({a, 1'b0}, ack);
        chk(15'(ack), 15'(a == ADR_A || a == ADR_B));
        if (ack) begin
            tx(o, ack);
            for (int k = 0; k < n; k++) begin
                b = (k == n - 1) ? d[7:0] : d[15:8];
                tx(b, ack);
                chk(15'(ack), 15'h1);
                if (rid(8'(o + k)) >= 0) mreg[a == ADR_B][rid(8'(o + k))] = b;
            end
        end
        cond(1'b0, 1'b1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] o, input int n);
        logic ack;
        logic s;
        logic [7:0] b;
        logic [7:0] e;
        cond(1'b1, 1'b0);
        tx({a, 1'b0}, ack);
        tx(o, ack);
        cond(1'b1, 1'b0);
        tx({a, 1'b1}, ack);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                bitx(1'b1, s);
                b[i] = s;
            end
            bitx(k == n - 1, s);
            e = (rid(8'(o + k)) < 0) ? 8'h00 :
                mreg[a == ADR_B][rid(8'(o + k))];
            chk(15'(b), 15'(e));
        end
        cond(1'b0, 1'b1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ********************************
    // scenarios
    // ********************************
    // hang guard
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        fail_count++;
        end_sim;
    end
    initial begin
        foreach (mreg[i, j]) mreg[i][j] = 8'h00;
        tick(16);
        rst_n_in = 1'b1;
        tick(4);
        chk_all;
        rd(ADR_A, 8'hC3, 2);
        rd(ADR_B, 8'h00, 1);
        $display("test reset_state done");
        // every code on both variants, unused upper bits random
        for (int f = 0; f < 16; f++) begin
            seed = lfsr(seed);
            wr(ADR_A, 8'h00, 1, {8'h00, seed[7:4], 4'(f)});
            wr(ADR_B, 8'h00, 1, {8'h00, seed[11:8], 4'(f)});
            chk_all;
        end
        rd(ADR_A, 8'h00, 1);
        $display("test format_codes done");
        // manual routing, selector pair written by auto increment
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = (i % 3 == 0) ? 4'h9 : (i % 3 == 1) ? 4'h6 : seed[3:0];
            wr(ADR_A, 8'h00, 1, {12'h000, v});
            wr(ADR_B, 8'h00, 1, {12'h000, v});
            wr(ADR_A, 8'hC3, 2, {seed[15:8], 1'b1, seed[22:16]});
            wr(ADR_B, 8'hC3, 2, {seed[31:24], 1'b1, seed[22:16]});
            chk_all;
            rd(ADR_B, 8'hC3, 2);
        end
        // selectors still set, enable cleared: predefined again
        wr(ADR_A, 8'hC4, 1, 16'h0007);
        wr(ADR_B, 8'hC4, 1, 16'h0005);
        chk_all;
        $display("test manual_route done");
        // unmapped offset and a foreign address change nothing
        wr(ADR_A, 8'h05, 1, 16'h005A);
        rd(ADR_A, 8'h05, 1);
        wr(7'h33, 8'h00, 1, 16'h000B);
        chk_all;
        $display("test refused_access done");
        // reset in mid-run with manual routing on
        wr(ADR_A, 8'hC4, 1, 16'h0085);
        rst_n_in = 1'b0;
        tick(3);
        rst_n_in = 1'b1;
        foreach (mreg[i, j]) mreg[i][j] = 8'h00;
        tick(4);
        chk_all;
        rd(ADR_A, 8'hC4, 1);
        $display("test mid_reset done");
        end_sim;
    end
endmodule

// File: vir_assertions.sv
/*
 * Port-level properties of the route select top.
 * Assumes binding onto every vir_top, one clock.
 */
`timescale 1ns/1ps
module vir_chk #(
    parameter SIX_INPUT = 1
) (
    input logic clk_sys_in,
    input logic rst_n_in,
    input logic scl_in,
    input logic sda_oe_out,
    input logic [2:0] mux_first_out,
    input logic [2:0] mux_second_out,
    input logic [2:0] mux_third_out,
    input logic [2:0] chan_power_out,
    input logic [1:0] core_format_out,
    input logic route_valid_out,
    input logic manual_active_out
);
    localparam int MAXIN = SIX_INPUT ? 6 : 3;

    // ********************************
    // sequences and properties
    // ********************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    // bus quiet long enough for a stored write to reach the outputs
    sequence scl_idle_s;
        scl_in [*6];
    endsequence
    sequence rst_done_s;
        $rose(rst_n_in);
    endsequence

    reserved_idle_a: assert property (
        !route_valid_out |-> mux_first_out == 3'h0 && mux_second_out == 3'h0
            && mux_third_out == 3'h0 && chan_power_out == 3'h0)
        else $error("routing active on a reserved code");
    valid_core_a: assert property (
        route_valid_out == (core_format_out != 2'h0))
        else $error("valid flag and core format disagree");
    composite_one_a: assert property (
        core_format_out == 2'h1 |-> chan_power_out == 3'h1
            && mux_second_out == 3'h0 && mux_third_out == 3'h0)
        else $error("composite uses more than one channel");
    luma_pair_a: assert property (
        core_format_out == 2'h2 |-> chan_power_out == 3'h3
            && mux_third_out == 3'h0)
        else $error("luma chroma channel use wrong");
    component_all_a: assert property (
        core_format_out == 2'h3 |-> chan_power_out == 3'h7)
        else $error("component does not power all channels");
    input_range_a: assert property (
        mux_first_out <= MAXIN && mux_second_out <= MAXIN
            && mux_third_out <= MAXIN)
        else $error("mux selects an absent input");
    reset_manual_a: assert property (
        rst_done_s |-> !manual_active_out [*3])
        else $error("manual routing on after reset");
    route_hold_a: assert property (
        scl_idle_s |-> $stable(core_format_out) && $stable(mux_first_out)
            && $stable(manual_active_out))
        else $error("routing changed with the bus idle");
    ack_scl_low_a: assert property (
        $changed(sda_oe_out) |-> !scl_in)
        else $error("data line changed while clock high");
endmodule

bind vir_top vir_chk #(.SIX_INPUT(SIX_INPUT)) i_chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
    .sda_oe_out(sda_oe_out), .mux_first_out(mux_first_out),
    .mux_second_out(mux_second_out), .mux_third_out(mux_third_out),
    .chan_power_out(chan_power_out), .core_format_out(core_format_out),
    .route_valid_out(route_valid_out),
    .manual_active_out(manual_active_out));

// File: vir_map.vh
/*
 * Register map, fields, reset values and codes of the route select.
 * Assumes inclusion by bare name.
 */
// Behaviour
// [RL1] Bits 3:0 of 0x00 hold the format code for routing and core mode.
// [RL2] Six-input codes 0000 to 0101 give composite on inputs 1 to 6.
// [RL3] Six-input codes 0110, 0111, 1000 give luma/chroma on 1/4, 2/5, 3/6.
// [RL4] Six-input 1001: component Y1 Pb4 Pr5; 1010: Y2 Pb3 Pr6; 1011 up: none.
// [RL5] Three-input 0000, 0011, 0100 give composite on inputs 1, 2, 3.
// [RL6] Three-input 0110 gives luma on input 1 and chroma on input 2.
// [RL7] Three-input 1001 is component Y1 Pb2 Pr3; other codes are reserved.
// [RL8] A predefined composite scheme powers down the idle channels.
// [RL9] Manual mux fields act only while bit 7 of 0xC4 is 1.
// [RL10] Selectors sit in 0xC3 bits 2:0, 0xC3 bits 6:4 and 0xC4 bits 2:0.
// [RL11] Core format always follows the format code, manual or not.
// [RL12] Software routes the input carrying sync through the first selector.
// [RL13] Software puts luma on the first selector, chroma on the second.
// [RL14] Software powers down muxes that carry no video.
// [RL15] Composite uses mux one, luma/chroma muxes one and two, component all.
// [RL16] A reserved code disconnects the converter and raises no fault.
// [RL17] After reset the manual enable bit reads 0.
`ifndef VIR_MAP_VH
`define VIR_MAP_VH

// ********************************
// register offsets and fields
// ********************************
`define VIR_OFS_INPUT_ROUTE_SELECT 8'h00
`define VIR_OFS_ADC_ROUTE_LOW 8'hC3
`define VIR_OFS_ADC_ROUTE_MANUAL 8'hC4
`define VIR_FMT_SEL_MSB 3
`define VIR_FMT_SEL_LSB 0
`define VIR_ROUTE_FIRST_MSB 2
`define VIR_ROUTE_FIRST_LSB 0
`define VIR_ROUTE_SECOND_MSB 6
`define VIR_ROUTE_SECOND_LSB 4
`define VIR_ROUTE_THIRD_MSB 2
`define VIR_ROUTE_THIRD_LSB 0
`define VIR_MANUAL_EN_BIT 7

// ********************************
// reset values
// ********************************
`define VIR_RST_INPUT_ROUTE_SELECT 8'h00
`define VIR_RST_ADC_ROUTE_LOW 8'h00
`define VIR_RST_ADC_ROUTE_MANUAL 8'h00

// ********************************
// core formats and serial port addressing
// ********************************
`define VIR_CORE_NONE 2'h0
`define VIR_CORE_COMPOSITE 2'h1
`define VIR_CORE_LUMA_CHROMA 2'h2
`define VIR_CORE_COMPONENT 2'h3
`define VIR_DEV_ADDR_BASE 7'h20
`define VIR_NO_INPUT 3'h0

`endif

// File: vir_route_dec.v
/*
 * Route decoder: format code and manual fields to mux, power, format.
 * Assumes same-clock register inputs.
 */
`timescale 1ns/1ps
`include "vir_map.vh"

module vir_route_dec #(
    parameter SIX_INPUT = 1
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [3:0] fmt_sel_in,
    input wire manual_en_in,
    input wire [2:0] route_first_in,
    input wire [2:0] route_second_in,
    input wire [2:0] route_third_in,
    output reg [2:0] mux_first_out,
    output reg [2:0] mux_second_out,
    output reg [2:0] mux_third_out,
    output reg [2:0] chan_power_out,
    output reg [1:0] core_format_out,
    output reg route_valid_out
);

    // ********************************
    // predefined schemes: {format, first, second, third}, format 2 bits, selectors 3 bits each
    // ********************************
    function [10:0] scheme;
        input [3:0] code;
        input six;
        begin
            scheme = {`VIR_CORE_NONE, 9'h000}; // [RL16]
            if (six) begin
                case (code)
                    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
                        scheme = {`VIR_CORE_COMPOSITE, code[2:0] + 3'h1,
                                  6'h00}; // [RL2]
                    end
                    4'h6: scheme = {`VIR_CORE_LUMA_CHROMA, 9'h060}; // [RL3]
                    4'h7: scheme = {`VIR_CORE_LUMA_CHROMA, 9'h0A8}; // [RL3]
                    4'h8: scheme = {`VIR_CORE_LUMA_CHROMA, 9'h0F0}; // [RL3]
                    4'h9: scheme = {`VIR_CORE_COMPONENT, 9'h065}; // [RL4]
                    4'hA: scheme = {`VIR_CORE_COMPONENT, 9'h09E}; // [RL4]
                    default: scheme = {`VIR_CORE_NONE, 9'h000}; // [RL4]
                endcase
            end else begin
                case (code)
                    4'h0: scheme = {`VIR_CORE_COMPOSITE, 9'h040}; // [RL5]
                    4'h3: scheme = {`VIR_CORE_COMPOSITE, 9'h080}; // [RL5]
                    4'h4: scheme = {`VIR_CORE_COMPOSITE, 9'h0C0}; // [RL5]
                    4'h6: scheme = {`VIR_CORE_LUMA_CHROMA, 9'h050}; // [RL6]
                    4'h9: scheme = {`VIR_CORE_COMPONENT, 9'h053}; // [RL7]
                    default: scheme = {`VIR_CORE_NONE, 9'h000}; // [RL7]
                endcase
            end
        end
    endfunction

    // ********************************
    // manual selector code to analog input number, 0 = no connect
    // ********************************
    function [2:0] mux_map;
        input [1:0] idx;
        input [2:0] code;
        input six;
        begin
            mux_map = `VIR_NO_INPUT;
            if (six) begin
                case (idx)
                    2'd0: if (code != 3'h0 && code != 3'h7) mux_map = code;
                    2'd1: if (code >= 3'h3 && code != 3'h7) mux_map = code;
                    default: begin
                        if (code == 3'h2 || code == 3'h5 || code == 3'h6) begin
                            mux_map = code;
                        end
                    end
                endcase
            end else begin
                // small parts reuse the upper codes for inputs 2 and 3
                if (code == 3'h4 && idx != 2'd2) mux_map = 3'h2;
                if (code == 3'h5) mux_map = 3'h3;
                if (code == 3'h1 && idx == 2'd0) mux_map = 3'h1;
            end
        end
    endfunction

    reg [10:0] pre;
    reg [1:0] fmt;
    reg [2:0] m0_nxt;
    reg [2:0] m1_nxt;
    reg [2:0] m2_nxt;

    // ********************************
    // route selection
    // ********************************
    // core format follows the select field even under manual routing
    always @* begin
        pre = scheme(fmt_sel_in, SIX_INPUT != 0); // [RL1]
        fmt = pre[10:9]; // [RL11]
        if (manual_en_in) begin // [RL9]
            m0_nxt = mux_map(2'd0, route_first_in, SIX_INPUT != 0);
            m1_nxt = mux_map(2'd1, route_second_in, SIX_INPUT != 0);
            m2_nxt = mux_map(2'd2, route_third_in, SIX_INPUT != 0);
        end else begin
            m0_nxt = pre[8:6];
            m1_nxt = pre[5:3];
            m2_nxt = pre[2:0];
        end
        // muxes beyond what the format needs stay open
        if (fmt == `VIR_CORE_NONE) m0_nxt = `VIR_NO_INPUT; // [RL16]
        if (fmt < `VIR_CORE_LUMA_CHROMA) m1_nxt = `VIR_NO_INPUT; // [RL15]
        if (fmt != `VIR_CORE_COMPONENT) m2_nxt = `VIR_NO_INPUT; // [RL15]
    end

    // registered outputs; one cycle after a register change
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mux_first_out <= 3'h0;
            mux_second_out <= 3'h0;
            mux_third_out <= 3'h0;
            chan_power_out <= 3'h0;
            core_format_out <= 2'h0;
            route_valid_out <= 1'b0;
        end else begin
            mux_first_out <= m0_nxt;
            mux_second_out <= m1_nxt;
            mux_third_out <= m2_nxt;
            chan_power_out <= {fmt == `VIR_CORE_COMPONENT,
                               fmt >= `VIR_CORE_LUMA_CHROMA,
                               fmt != `VIR_CORE_NONE}; // [RL8]
            core_format_out <= fmt; // [RL11]
            route_valid_out <= (fmt != `VIR_CORE_NONE); // [RL16]
        end
    end

endmodule

// File: vir_top.v
/*
 * Route select top: serial register port and route registers,
 * feeding the route decoder.
 * Assumes asynchronous pin inputs
 * and a clock far above the bus rate.
 */
`timescale 1ns/1ps
`include "vir_map.vh"

module vir_top #(
    parameter SIX_INPUT = 1
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire scl_in,
    input wire sda_in,
    input wire alsb_in,
    output reg sda_out,
    output reg sda_oe_out,
    output wire [2:0] mux_first_out,
    output wire [2:0] mux_second_out,
    output wire [2:0] mux_third_out,
    output wire [2:0] chan_power_out,
    output wire [1:0] core_format_out,
    output wire route_valid_out,
    output reg manual_active_out
);

    localparam ST_IDLE = 5'b00001;
    localparam ST_RX = 5'b00010;
    localparam ST_ACK = 5'b00100;
    localparam ST_TX = 5'b01000;
    localparam ST_RACK = 5'b10000;

    localparam PH_ADDR = 2'd0;
    localparam PH_SUB = 2'd1;
    localparam PH_DATA = 2'd2;

    // ********************************
    // pin synchronisers
    // ********************************
    reg scl_m_r, scl_s_r, scl_d_r;
    reg sda_m_r, sda_s_r, sda_d_r;
    reg alsb_m_r, alsb_s_r;

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
            alsb_m_r <= 1'b0;
            alsb_s_r <= 1'b0;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            alsb_m_r <= alsb_in;
            alsb_s_r <= alsb_m_r;
        end
    end

    wire scl_rise = scl_s_r & ~scl_d_r;
    wire scl_fall = ~scl_s_r & scl_d_r;
    wire bus_start = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
    wire bus_stop = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;

    // ********************************
    // registers
    // ********************************
    reg [7:0] fmt_reg_r;
    reg [7:0] route_low_r;
    reg [7:0] route_man_r;

    // unmapped offsets read as zero
    function [7:0] reg_read;
        input [7:0] ofs;
        input [7:0] r0;
        input [7:0] r1;
        input [7:0] r2;
        begin
            case (ofs)
                `VIR_OFS_INPUT_ROUTE_SELECT: reg_read = r0;
                `VIR_OFS_ADC_ROUTE_LOW: reg_read = r1;
                `VIR_OFS_ADC_ROUTE_MANUAL: reg_read = r2;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    // ********************************
    // serial slave
    // ********************************
    reg [4:0] st_r;
    reg [1:0] ph_r;
    reg [3:0] bit_r;
    reg [7:0] shf_r;
    reg [7:0] tx_r;
    reg [7:0] ptr_r;
    reg rw_r;
    reg mack_r;

    wire [7:0] rd_byte = reg_read(ptr_r, fmt_reg_r, route_low_r,
                                  route_man_r);
    wire addr_hit = (shf_r[7:1] == (`VIR_DEV_ADDR_BASE | {6'h00, alsb_s_r}));

    // one process for all bus events; start and stop win over bit edges
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_IDLE;
            ph_r <= PH_ADDR;
            bit_r <= 4'h0;
            shf_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe_out <= 1'b0;
            sda_out <= 1'b0;
            fmt_reg_r <= `VIR_RST_INPUT_ROUTE_SELECT;
            route_low_r <= `VIR_RST_ADC_ROUTE_LOW;
            route_man_r <= `VIR_RST_ADC_ROUTE_MANUAL; // [RL17]
            manual_active_out <= 1'b0;
        end else begin
            manual_active_out <= route_man_r[`VIR_MANUAL_EN_BIT]; // [RL9]
            if (bus_start) begin
                st_r <= ST_RX;
                ph_r <= PH_ADDR;
                bit_r <= 4'h0;
                sda_oe_out <= 1'b0;
            end else if (bus_stop) begin
                st_r <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end else begin
                case (st_r)
                    ST_RX: begin
                        if (scl_rise) begin
                            shf_r <= {shf_r[6:0], sda_s_r};
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall && bit_r == 4'h8) begin
                            st_r <= ST_ACK;
                            sda_oe_out <= 1'b1;
                            if (ph_r == PH_ADDR) begin
                                rw_r <= shf_r[0];
                                if (!addr_hit) begin
                                    st_r <= ST_IDLE;
                                    sda_oe_out <= 1'b0;
                                end
                            end else if (ph_r == PH_SUB) begin
                                ptr_r <= shf_r;
                            end else begin
                                ptr_r <= ptr_r + 8'h01;
                                case (ptr_r)
                                    `VIR_OFS_INPUT_ROUTE_SELECT:
                                        fmt_reg_r <= shf_r; // [RL1]
                                    `VIR_OFS_ADC_ROUTE_LOW:
                                        route_low_r <= shf_r; // [RL10]
                                    `VIR_OFS_ADC_ROUTE_MANUAL:
                                        route_man_r <= shf_r; // [RL10]
                                    default: ;
                                endcase
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_r <= 4'h0;
                            if (ph_r == PH_ADDR && rw_r) begin
                                st_r <= ST_TX;
                                tx_r <= rd_byte;
                                ptr_r <= ptr_r + 8'h01;
                                sda_oe_out <= ~rd_byte[7];
                            end else begin
                                st_r <= ST_RX;
                                sda_oe_out <= 1'b0;
                                if (ph_r != PH_DATA) ph_r <= ph_r + 2'd1;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_r == 4'h7) begin
                                st_r <= ST_RACK;
                                sda_oe_out <= 1'b0;
                            end else begin
                                tx_r <= {tx_r[6:0], 1'b0};
                                sda_oe_out <= ~tx_r[6];
                                bit_r <= bit_r + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            mack_r <= ~sda_s_r;
                        end else if (scl_fall) begin
                            // a master nack ends the read until the next start
                            if (mack_r) begin
                                st_r <= ST_TX;
                                bit_r <= 4'h0;
                                tx_r <= rd_byte;
                                ptr_r <= ptr_r + 8'h01;
                                sda_oe_out <= ~rd_byte[7];
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_IDLE: ;
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ********************************
    // route decoder
    // ********************************
    vir_route_dec #(
        .SIX_INPUT(SIX_INPUT)
    ) u_dec (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .fmt_sel_in(fmt_reg_r[`VIR_FMT_SEL_MSB:`VIR_FMT_SEL_LSB]),
        .manual_en_in(route_man_r[`VIR_MANUAL_EN_BIT]),
        .route_first_in(route_low_r[`VIR_ROUTE_FIRST_MSB:
                                    `VIR_ROUTE_FIRST_LSB]),
        .route_second_in(route_low_r[`VIR_ROUTE_SECOND_MSB:
                                     `VIR_ROUTE_SECOND_LSB]),
        .route_third_in(route_man_r[`VIR_ROUTE_THIRD_MSB:
                                    `VIR_ROUTE_THIRD_LSB]),
        .mux_first_out(mux_first_out),
        .mux_second_out(mux_second_out),
        .mux_third_out(mux_third_out),
        .chan_power_out(chan_power_out),
        .core_format_out(core_format_out),
        .route_valid_out(route_valid_out)
    );

endmodule
